// ---- verilog/cesi_pkg.sv ----
// Shared constants for the CAN error state and interrupt logic.
`default_nettype none
package cesi_pkg;
  // Timing.
  localparam int CLK_NS      = 4;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYC     = BIT_TIME_NS / CLK_NS;
  // Error counter limits and steps.
  localparam logic [8:0] WARN_LIM    = 9'h060;
  localparam logic [8:0] PASS_LIM    = 9'h080;
  localparam logic [8:0] BOFF_LIM    = 9'h100;
  localparam logic [8:0] TEC_STEP    = 9'h008;
  localparam logic [7:0] REC_MAX     = 8'hff;
  localparam logic [2:0] STUFF_LIM   = 3'h6;
  localparam logic [2:0] EFLAG_LEN   = 3'h6;
  localparam logic [3:0] RECOV_BITS  = 4'hb;
  localparam logic [6:0] RECOV_SEQS  = 7'h7f;
  // Register offsets.
  localparam logic [2:0] OFS_FLAG    = 3'h0;
  localparam logic [2:0] OFS_ENABLE  = 3'h1;
  localparam logic [2:0] OFS_COMM    = 3'h2;
  localparam logic [2:0] OFS_CTRLST  = 3'h3;
  localparam logic [2:0] OFS_REC     = 3'h4;
  localparam logic [2:0] OFS_TEC     = 3'h5;
  localparam logic [2:0] OFS_SLEEP   = 3'h6;
  // Interrupt flag and enable bit positions.
  localparam int F_ERR  = 0;
  localparam int F_WAK  = 1;
  localparam int F_TX0  = 2;
  localparam int F_RX0  = 5;
  localparam int F_MERR = 7;
  // Communication status bit positions.
  localparam int C_OVF0  = 0;
  localparam int C_RXW   = 2;
  localparam int C_BOFF  = 6;
  localparam int C_ERROR_WARNING_FLAG = 7;
  // Reset values.
  localparam logic [7:0] RST_FLAG   = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  // Error modes.
  localparam logic [1:0] MODE_ACTIVE  = 2'h0;
  localparam logic [1:0] MODE_PASSIVE = 2'h1;
  localparam logic [1:0] MODE_BOFF    = 2'h2;
endpackage
`default_nettype wire

// ---- verilog/cesi_if.sv ----
// Bit-level bus between this node's error logic and the far node.
`timescale 1ns/10ps
`default_nettype none
interface cesi_if;
  logic bit_en;
  logic dev_tx;
  logic node_tx;
  logic bus_lvl;
  // Wired-AND: dominant (0) from either node wins.
  assign bus_lvl = dev_tx & node_tx;
  modport dev (input bit_en, input bus_lvl, output dev_tx);
  modport node (output bit_en, output node_tx, input bus_lvl);
endinterface
`default_nettype wire

// ---- verilog/cesi_node.sv ----
// Far CAN node: bit timing source and bus driver.
`timescale 1ns/10ps
`default_nettype none
module cesi_node #(
  parameter int BIT_CYC = cesi_pkg::BIT_CYC
) (
  // Clock and reset.
  input  wire logic CLK_SYS,
  input  wire logic RESET,
  // Bus.
  cesi_if.node      LINK,
  // User side.
  input  wire logic DOM_REQ,
  output logic      BIT_TICK,
  output logic      BUS_SEEN
);
  typedef struct packed {
    logic [15:0] div;
    logic        tick;
    logic        tx;
    logic        seen;
  } cesi_node_t;

  cesi_node_t s_ff;
  cesi_node_t nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.div == 16'(BIT_CYC - 1)) begin
      nxt_s.div  = 16'h0000;
      nxt_s.tick = 1'b1;
      // The bus is sampled and the next bit driven on the same tick.
      nxt_s.seen = LINK.bus_lvl;
      nxt_s.tx   = ~DOM_REQ;
    end else begin
      nxt_s.div = s_ff.div + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_ff <= '{div: 16'h0000, tick: 1'b0, tx: 1'b1, seen: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign LINK.bit_en  = s_ff.tick;
  assign LINK.node_tx = s_ff.tx;
  assign BIT_TICK     = s_ff.tick;
  assign BUS_SEEN     = s_ff.seen;
endmodule
`default_nettype wire

// ---- verilog/cesi_dev.sv ----
// Error state, error counters and interrupt logic of this CAN node.
// Summary of operation
// - Transmitter flags mismatch between sent and read.
// - No bit error for lost arbitration/ack.
// - Six equal bits in stuffed region: error.
// - Errors send error frame, abort, retry.
// - Active sends dominant flags, passive recessive.
// - Bus-off node neither sends nor receives.
// - Separate readable counters; mode in status.
// - Passive when either counter reaches 128.
// - Bus-off at transmit count 256, held.
// - 128 runs of 11 recessive recover.
// - Warning flag at 96, per-counter warnings.
// - Eight flags, each with own enable.
// - Three-bit source code, lower is higher.
// - Code order err, wake, tx0-2, rx0-1.
// - Only enabled sources shape the code.
// - Buffer empty sets tx flag; write 0 clears.
// - Good frame sets rx flag; write 0 clears.
// - Any frame error sets message error flag.
// - Bus activity in sleep with wake enabled sets wake, wakes.
// - Overflow or state change sets error flag.
// - Full target buffer sets overflow bit.
// - Flag clear ignored while cause remains.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module cesi_dev (
  // Clock and reset.
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  // Bus.
  cesi_if.dev             LINK,
  // Register port.
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Protocol engine.
  input  wire logic       TX_ACTIVE,
  input  wire logic       TX_BIT,
  input  wire logic       IN_ARB,
  input  wire logic       IN_ACK,
  input  wire logic       IN_STUFF,
  input  wire logic       PROTO_ERR,
  input  wire logic       TX_OK,
  input  wire logic       RX_OK,
  input  wire logic       RX_DONE,
  input  wire logic       RX_SEL,
  input  wire logic [1:0] RX_FULL,
  input  wire logic [2:0] TX_EMPTY,
  // Status outputs.
  output logic            IRQ,
  output logic            RETRY,
  output logic            BUS_OFF,
  output logic            SLEEP_O
);
  typedef struct packed {
    logic       tx;
    logic       last;
    logic [2:0] run;
    logic [2:0] eflag;
    logic [8:0] tec;
    logic [7:0] rec;
    logic       boff;
    logic [3:0] rcnt;
    logic [6:0] ocnt;
    logic [7:0] flag;
    logic [7:0] en;
    logic [7:0] comm;
    logic       sleep;
    logic       retry;
    logic       irq;
    logic [7:0] rdata;
  } cesi_dev_t;

  cesi_dev_t s_ff;
  cesi_dev_t nxt_s;

  // Lowest pending index of 0 to 6 wins; code is index plus one, zero when none of those is pending.
  function automatic logic [2:0] cesi_irq_source_code(input logic [7:0] pend);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (pend[i]) begin
        c = 3'(i + 1);
      end
    end
    return c;
  endfunction

  function automatic logic [1:0] cesi_mode(input cesi_dev_t v);
    logic [1:0] m;
    if (v.boff) begin
      m = cesi_pkg::MODE_BOFF;
    end else if (v.tec >= cesi_pkg::PASS_LIM || {1'b0, v.rec} >= cesi_pkg::PASS_LIM) begin
      m = cesi_pkg::MODE_PASSIVE;
    end else begin
      m = cesi_pkg::MODE_ACTIVE;
    end
    return m;
  endfunction

  logic       b;
  logic       passive;
  logic       berr;
  logic       serr;
  logic       err;
  logic [2:0] run_n;
  logic [7:0] fset;
  logic [7:0] fhold;
  logic [4:0] lvl;
  logic [1:0] ovf_set;

  always_comb begin
    nxt_s   = s_ff;
    b       = LINK.bus_lvl;
    passive = cesi_mode(s_ff) == cesi_pkg::MODE_PASSIVE;
    berr    = 1'b0;
    serr    = 1'b0;
    run_n   = 3'h0;
    fset    = 8'h00;
    ovf_set = 2'b00;
    nxt_s.retry = 1'b0;

    if (LINK.bit_en) begin
      if (s_ff.sleep && s_ff.en[cesi_pkg::F_WAK] && !b) begin
        fset[cesi_pkg::F_WAK] = 1'b1;
        nxt_s.sleep           = 1'b0;
      end
      if (s_ff.boff) begin
        // Recovery counts runs of recessive bits; a dominant bit restarts the run.
        if (!b) begin
          nxt_s.rcnt = 4'h0;
        end else if (s_ff.rcnt == cesi_pkg::RECOV_BITS - 4'h1) begin
          nxt_s.rcnt = 4'h0;
          if (s_ff.ocnt == cesi_pkg::RECOV_SEQS) begin
            nxt_s.boff = 1'b0;
            nxt_s.ocnt = 7'h00;
            nxt_s.tec  = 9'h000;
            nxt_s.rec  = 8'h00;
          end else begin
            nxt_s.ocnt = s_ff.ocnt + 7'h01;
          end
        end else begin
          nxt_s.rcnt = s_ff.rcnt + 4'h1;
        end
      end else begin
        // Losing arbitration or getting an ack reads dominant over our recessive.
        berr = TX_ACTIVE && s_ff.eflag == 3'h0 && s_ff.tx != b
               && !(s_ff.tx && !b && (IN_ARB || IN_ACK));
        if (IN_STUFF) begin
          run_n = (b == s_ff.last) ? s_ff.run + 3'h1 : 3'h1;
          serr  = run_n == cesi_pkg::STUFF_LIM;
        end
        nxt_s.run  = serr ? 3'h0 : run_n;
        nxt_s.last = b;
      end
    end

    err = !s_ff.boff && (berr || serr || PROTO_ERR);
    if (err) begin
      fset[cesi_pkg::F_MERR] = 1'b1;
      nxt_s.eflag = cesi_pkg::EFLAG_LEN;
      nxt_s.retry = TX_ACTIVE;
      if (TX_ACTIVE) begin
        nxt_s.tec = (s_ff.tec + cesi_pkg::TEC_STEP > cesi_pkg::BOFF_LIM)
                    ? cesi_pkg::BOFF_LIM : s_ff.tec + cesi_pkg::TEC_STEP;
      end else if (s_ff.rec != cesi_pkg::REC_MAX) begin
        nxt_s.rec = s_ff.rec + 8'h01;
      end
    end else if (!s_ff.boff) begin
      if (TX_OK && s_ff.tec != 9'h000) begin
        nxt_s.tec = s_ff.tec - 9'h001;
      end
      if (RX_OK && s_ff.rec != 8'h00) begin
        nxt_s.rec = s_ff.rec - 8'h01;
      end
    end
    if (!s_ff.boff && nxt_s.tec >= cesi_pkg::BOFF_LIM) begin
      nxt_s.boff  = 1'b1;
      nxt_s.eflag = 3'h0;
      nxt_s.rcnt  = 4'h0;
      nxt_s.ocnt  = 7'h00;
    end

    if (LINK.bit_en) begin
      if (nxt_s.boff) begin
        nxt_s.tx = 1'b1;
      end else if (s_ff.eflag != 3'h0) begin
        nxt_s.tx    = passive;
        nxt_s.eflag = err ? nxt_s.eflag : s_ff.eflag - 3'h1;
      end else begin
        nxt_s.tx = TX_ACTIVE ? TX_BIT : 1'b1;
      end
    end

    // Completed frames are dropped while bus-off.
    if (RX_DONE && !s_ff.boff) begin
      if (RX_FULL[RX_SEL]) begin
        ovf_set[RX_SEL]       = 1'b1;
        fset[cesi_pkg::F_ERR] = 1'b1;
      end else begin
        fset[cesi_pkg::F_RX0 + int'(RX_SEL)] = 1'b1;
      end
    end
    fset[cesi_pkg::F_TX0 +: 3] = TX_EMPTY;

    lvl = {nxt_s.boff,
           nxt_s.tec >= cesi_pkg::PASS_LIM, {1'b0, nxt_s.rec} >= cesi_pkg::PASS_LIM,
           nxt_s.tec >= cesi_pkg::WARN_LIM, {1'b0, nxt_s.rec} >= cesi_pkg::WARN_LIM};
    if (lvl != s_ff.comm[cesi_pkg::C_BOFF:cesi_pkg::C_RXW]) begin
      fset[cesi_pkg::F_ERR] = 1'b1;
    end
    nxt_s.comm[cesi_pkg::C_BOFF:cesi_pkg::C_RXW] = lvl;
    nxt_s.comm[cesi_pkg::C_ERROR_WARNING_FLAG] = lvl[0] | lvl[1];

    // A flag whose cause is present this cycle cannot be cleared.
    fhold                 = fset;
    fhold[cesi_pkg::F_ERR] = fset[cesi_pkg::F_ERR]
                            | (|s_ff.comm[cesi_pkg::C_OVF0 +: 2]);

    nxt_s.comm[cesi_pkg::C_OVF0 +: 2] = s_ff.comm[cesi_pkg::C_OVF0 +: 2] | ovf_set;
    nxt_s.flag = s_ff.flag | fset;
    if (WR) begin
      if (ADDR == cesi_pkg::OFS_FLAG) begin
        nxt_s.flag = (s_ff.flag & WDATA) | fhold | fset;
      end else if (ADDR == cesi_pkg::OFS_ENABLE) begin
        nxt_s.en = WDATA;
      end else if (ADDR == cesi_pkg::OFS_COMM) begin
        nxt_s.comm[cesi_pkg::C_OVF0 +: 2] = (s_ff.comm[cesi_pkg::C_OVF0 +: 2]
                                            & WDATA[cesi_pkg::C_OVF0 +: 2]) | ovf_set;
      end else if (ADDR == cesi_pkg::OFS_SLEEP) begin
        nxt_s.sleep = WDATA[0];
      end
    end

    nxt_s.irq = |(nxt_s.flag & nxt_s.en);

    nxt_s.rdata = 8'h00;
    if (RD) begin
      if (ADDR == cesi_pkg::OFS_FLAG) begin
        nxt_s.rdata = s_ff.flag;
      end else if (ADDR == cesi_pkg::OFS_ENABLE) begin
        nxt_s.rdata = s_ff.en;
      end else if (ADDR == cesi_pkg::OFS_COMM) begin
        nxt_s.rdata = s_ff.comm;
      end else if (ADDR == cesi_pkg::OFS_CTRLST) begin
        nxt_s.rdata = {2'b00, s_ff.sleep, cesi_mode(s_ff),
                       cesi_irq_source_code(s_ff.flag & s_ff.en)};
      end else if (ADDR == cesi_pkg::OFS_REC) begin
        nxt_s.rdata = s_ff.rec;
      end else if (ADDR == cesi_pkg::OFS_TEC) begin
        // Bus-off value 256 reads as 255 on the byte-wide port.
        nxt_s.rdata = s_ff.tec[8] ? 8'hff : s_ff.tec[7:0];
      end else if (ADDR == cesi_pkg::OFS_SLEEP) begin
        nxt_s.rdata = {7'h00, s_ff.sleep};
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_ff      <= '0;
      s_ff.tx   <= 1'b1;
      s_ff.last <= 1'b1;
      s_ff.flag <= cesi_pkg::RST_FLAG;
      s_ff.en   <= cesi_pkg::RST_ENABLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign LINK.dev_tx = s_ff.tx;
  assign RDATA       = s_ff.rdata;
  assign IRQ         = s_ff.irq;
  assign RETRY       = s_ff.retry;
  assign BUS_OFF     = s_ff.boff;
  assign SLEEP_O     = s_ff.sleep;
endmodule
`default_nettype wire

// ---- sim/cesi_assertions.sv ----
// Wire-level checks on the link between the two ends.
`timescale 1ns/10ps
`default_nettype none
module cesi_assertions (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Link.
  input wire logic bit_en,
  input wire logic dev_tx,
  input wire logic node_tx,
  input wire logic bus_lvl
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  property p_rst_idle; $fell(RESET) |-> dev_tx && node_tx && !bit_en; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
  property p_wired_and; bus_lvl == (dev_tx & node_tx); endproperty
  a_wired_and: assert property (p_wired_and) else $error("bus level not wired-and");
  // The drive may move only in the cycle after the device sampled a bit.
  property p_dev_on_tick; $changed(dev_tx) |-> $past(bit_en); endproperty
  a_dev_on_tick: assert property (p_dev_on_tick) else $error("device drive off tick");
  property p_tick_pulse; bit_en |=> !bit_en; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("bit tick longer than a cycle");
  // The bench runs the far node with a four-cycle bit.
  property p_tick_period; bit_en |=> !bit_en [*3] ##1 bit_en; endproperty
  a_tick_period: assert property (p_tick_period) else $error("bit tick spacing wrong");
  // The far node's drive and its tick are launched by the same edge.
  property p_node_moves; $changed(node_tx) |-> bit_en; endproperty
  a_node_moves: assert property (p_node_moves) else $error("far node drive off tick");
  property p_node_holds; $changed(node_tx) |=> $stable(node_tx) [*3]; endproperty
  a_node_holds: assert property (p_node_holds) else $error("far node drive not held");
  property p_dev_holds; $changed(dev_tx) |=> $stable(dev_tx); endproperty
  a_dev_holds: assert property (p_dev_holds) else $error("device drive glitch");
endmodule
`default_nettype wire

// ---- sim/cesi_tb.sv ----
// Bench joining the error logic to a far node across the bit link.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module cesi_tb;
  logic       clk, rst, wr, rd, dom, ta, tb, arb, stf, perr, rxd, rsel, bt, seen, lvl;
  logic       irq, retry, boff, slp, ack, tok, rok;
  logic [2:0] addr, txe;
  logic [1:0] rxf;
  logic [7:0] wd, rdat, v, fl;
  int         err_total, checked, n, ticks;
  cesi_if lk();
  cesi_node #(.BIT_CYC(4)) cesi_node_i (.CLK_SYS(clk), .RESET(rst), .LINK(lk.node),
    .DOM_REQ(dom), .BIT_TICK(bt), .BUS_SEEN(seen));
  cesi_dev cesi_dev_i (.CLK_SYS(clk), .RESET(rst), .LINK(lk.dev), .ADDR(addr), .WDATA(wd),
    .WR(wr), .RD(rd), .RDATA(rdat), .TX_ACTIVE(ta), .TX_BIT(tb), .IN_ARB(arb), .IN_ACK(ack),
    .IN_STUFF(stf), .PROTO_ERR(perr), .TX_OK(tok), .RX_OK(rok), .RX_DONE(rxd),
    .RX_SEL(rsel), .RX_FULL(rxf), .TX_EMPTY(txe), .IRQ(irq), .RETRY(retry), .BUS_OFF(boff),
    .SLEEP_O(slp));
  cesi_assertions cesi_assertions_i (.CLK_SYS(clk), .RESET(rst), .bit_en(lk.bit_en),
    .dev_tx(lk.dev_tx), .node_tx(lk.node_tx), .bus_lvl(lk.bus_lvl));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counts sampled bits while off the bus, to time the recovery.
  always @(posedge clk) begin
    if (bt === 1'b1 && boff === 1'b1) begin
      ticks <= ticks + 1;
    end
  end
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdat;
  endtask
  // Returns just after the edge that samples a bit.
  task automatic tick;
    do @(negedge clk); while (bt !== 1'b1);
    @(posedge clk);
    #1;
  endtask
  // One protocol error, then the lowest drive seen over the error frame.
  task automatic err;
    @(posedge clk);
    perr <= 1'b1;
    @(posedge clk);
    perr <= 1'b0;
    lvl = 1'b1;
    repeat (8) begin
      tick;
      if (lk.dev_tx === 1'b0) lvl = 1'b0;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic s_biterr;
    @(posedge clk);
    ta <= 1'b1;
    arb <= 1'b1;
    dom <= 1'b1;
    repeat (3) tick;
    rreg(cesi_pkg::OFS_TEC);
    `CHK("tec arb", 8'h00, v)
    @(posedge clk);
    arb <= 1'b0;
    ack <= 1'b1;
    repeat (2) tick;
    rreg(cesi_pkg::OFS_TEC);
    `CHK("tec ack", 8'h00, v)
    @(posedge clk);
    ack <= 1'b0;
    tick;
    `CHK("retry", 1'b1, retry)
    // The error flag goes out from the second bit after the one found in error.
    @(posedge clk);
    dom <= 1'b0;
    tick;
    `CHK("active flag", 1'b0, lk.dev_tx)
    tick;
    `CHK("far node sees flag", 1'b0, seen)
    rreg(cesi_pkg::OFS_TEC);
    `CHK("tec bit", 8'h08, v)
    rreg(cesi_pkg::OFS_FLAG);
    `CHK("merr", 8'h80, v)
    `CHK("irq masked", 1'b0, irq)
    wreg(cesi_pkg::OFS_ENABLE, 8'h80);
    repeat (2) @(negedge clk);
    `CHK("irq on", 1'b1, irq)
    wreg(cesi_pkg::OFS_ENABLE, 8'h00);
    wreg(cesi_pkg::OFS_FLAG, 8'h00);
  endtask
  task automatic s_climb;
    repeat (10) err;
    `CHK("active frame", 1'b0, lvl)
    rreg(cesi_pkg::OFS_COMM);
    `CHK("comm 88", 8'h00, v)
    err;
    rreg(cesi_pkg::OFS_COMM);
    `CHK("comm 96", 8'h88, v)
    rreg(cesi_pkg::OFS_FLAG);
    `CHK("err flag", 8'h81, v)
    repeat (4) err;
    rreg(cesi_pkg::OFS_CTRLST);
    `CHK("mode passive", 8'h08, v)
    rreg(cesi_pkg::OFS_COMM);
    `CHK("comm 128", 8'ha8, v)
    @(posedge clk);
    tok <= 1'b1;
    @(posedge clk);
    tok <= 1'b0;
    rreg(cesi_pkg::OFS_TEC);
    `CHK("tec ok", 8'h7f, v)
    rreg(cesi_pkg::OFS_CTRLST);
    `CHK("mode back active", 8'h00, v)
    err;
    `CHK("passive frame", 1'b1, lvl)
    repeat (15) err;
    @(posedge clk);
    perr <= 1'b1;
    tb <= 1'b0;
    @(posedge clk);
    perr <= 1'b0;
    rxd <= 1'b1;
    @(posedge clk);
    rxd <= 1'b0;
    `CHK("bus off", 1'b1, boff)
    rreg(cesi_pkg::OFS_TEC);
    `CHK("tec 256", 8'hff, v)
    rreg(cesi_pkg::OFS_CTRLST);
    `CHK("mode off", 8'h10, v)
    tick;
    `CHK("off drive", 1'b1, lk.dev_tx)
    @(posedge clk);
    ta <= 1'b0;
    tb <= 1'b1;
    for (n = 0; n < 6000 && boff !== 1'b0; n++) @(negedge clk);
    `CHK("recovery bits", 1408, ticks)
    rreg(cesi_pkg::OFS_TEC);
    `CHK("tec cleared", 8'h00, v)
    rreg(cesi_pkg::OFS_FLAG);
    `CHK("no rx in off", 8'h81, v)
    rreg(cesi_pkg::OFS_CTRLST);
    `CHK("mode active", 8'h00, v)
  endtask
  task automatic s_stuff;
    @(posedge clk);
    dom <= 1'b1;
    repeat (2) tick;
    @(posedge clk);
    stf <= 1'b1;
    repeat (5) tick;
    rreg(cesi_pkg::OFS_REC);
    `CHK("rec five", 8'h00, v)
    tick;
    rreg(cesi_pkg::OFS_REC);
    `CHK("rec six", 8'h01, v)
    @(posedge clk);
    stf <= 1'b0;
    dom <= 1'b0;
    rok <= 1'b1;
    @(posedge clk);
    rok <= 1'b0;
    rreg(cesi_pkg::OFS_REC);
    `CHK("rec ok", 8'h00, v)
  endtask
  task automatic s_irq;
    wreg(cesi_pkg::OFS_FLAG, 8'h00);
    wreg(cesi_pkg::OFS_ENABLE, 8'hff);
    @(posedge clk);
    txe <= 3'h7;
    rxd <= 1'b1;
    @(posedge clk);
    txe <= 3'h0;
    rsel <= 1'b1;
    @(posedge clk);
    rxd <= 1'b0;
    rreg(cesi_pkg::OFS_FLAG);
    `CHK("buffer flags", 8'h7c, v)
    rreg(cesi_pkg::OFS_CTRLST);
    `CHK("code tx0", 8'h03, v)
    wreg(cesi_pkg::OFS_ENABLE, 8'hfb);
    rreg(cesi_pkg::OFS_CTRLST);
    `CHK("code masked", 8'h04, v)
    wreg(cesi_pkg::OFS_ENABLE, 8'hff);
    fl = 8'h7c;
    for (int k = 0; k < 5; k++) begin
      fl[k + 2] = 1'b0;
      wreg(cesi_pkg::OFS_FLAG, fl);
      rreg(cesi_pkg::OFS_CTRLST);
      `CHK("code next", 8'(k == 4 ? 0 : k + 4), v)
    end
    `CHK("irq idle", 1'b0, irq)
    wreg(3'h7, 8'hff);
    wreg(cesi_pkg::OFS_FLAG, 8'h7f);
    rreg(3'h7);
    `CHK("unmapped", 8'h00, v)
    rreg(cesi_pkg::OFS_FLAG);
    `CHK("write one", 8'h00, v)
  endtask
  task automatic s_wake_ovf;
    wreg(cesi_pkg::OFS_SLEEP, 8'h01);
    repeat (2) @(negedge clk);
    `CHK("asleep", 1'b1, slp)
    @(posedge clk);
    dom <= 1'b1;
    repeat (2) tick;
    repeat (2) @(negedge clk);
    `CHK("awake", 1'b0, slp)
    rreg(cesi_pkg::OFS_CTRLST);
    `CHK("code wake", 8'h02, v)
    @(posedge clk);
    dom <= 1'b0;
    wreg(cesi_pkg::OFS_FLAG, 8'h00);
    @(posedge clk);
    rxd <= 1'b1;
    rsel <= 1'b0;
    rxf <= 2'h1;
    @(posedge clk);
    rxd <= 1'b0;
    rreg(cesi_pkg::OFS_COMM);
    `CHK("overflow", 8'h01, v)
    wreg(cesi_pkg::OFS_FLAG, 8'h00);
    rreg(cesi_pkg::OFS_FLAG);
    `CHK("err held", 8'h01, v)
    wreg(cesi_pkg::OFS_COMM, 8'h00);
    wreg(cesi_pkg::OFS_FLAG, 8'h00);
    rreg(cesi_pkg::OFS_FLAG);
    `CHK("err gone", 8'h00, v)
  endtask
  initial begin
    {rst, tb} = 2'h3;
    {wr, rd, dom, ta, arb, ack, tok, rok, stf, perr, rxd, rsel, addr, txe, rxf, wd} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rreg(3'(a));
      `CHK("reset value", 8'h00, v)
    end
    s_biterr;
    s_climb;
    s_stuff;
    s_irq;
    s_wake_ovf;
    report_and_stop;
  end
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
endmodule
`default_nettype wire
